// ===== pct_defs.svh
`ifndef PCT_DEFS_SVH
`define PCT_DEFS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PCT_CMD_TEMP_LAST 8'h07
`define PCT_CMD_MAX 8'h08
`define PCT_CMD_FW 8'h09
`define PCT_CMD_MAX_SRC 8'h0A
`define PCT_CMD_ALERT_SRC 8'h0B
`define PCT_CMD_CFG0 8'h0C
`define PCT_CMD_CFG1 8'h0D
`define PCT_CMD_CFG2 8'h0E
`define PCT_CMD_CFG3 8'h0F
`define PCT_CMD_LIM0 8'h10
`define PCT_CMD_LIM3 8'h13
`define PCT_CMD_POLL 8'h14
`define PCT_CMD_CLR_ALERT 8'h15
// ----------------------------------------
// main config field positions
// ----------------------------------------
`define PCT_C0_MASK_LSB 8
`define PCT_C0_TOUT_EN 7
`define PCT_C0_ALT 6
`define PCT_C0_PEC 5
`define PCT_C0_AMASK 4
`define PCT_C0_WMASK 16'hFFF7
// ----------------------------------------
// reset values and fixed codes
// ----------------------------------------
`define PCT_CFG0_RST 16'h00A5
`define PCT_CFG1_RST 16'h0203
`define PCT_CFG2_RST 16'h0000
`define PCT_CFG3_RST 16'h0000
`define PCT_LIMIT_RST 16'h7FFF
`define PCT_ERR_LO 16'h8000
`define PCT_ERR_HI 16'h81FF
`define PCT_NO_SRC 16'h00FF
`define PCT_PEC_POLY 8'h07
`define PCT_I2C_BASE 6'h14
`define PCT_FW_VERSION 16'h0100
// ----------------------------------------
// timing: 2.5 ms poll unit, 30 ms bus lockup
// ----------------------------------------
`define PCT_CLK_HZ 20000000
`define PCT_UNIT_US 2500
`define PCT_TOUT_US 30000
`define PCT_DLY1_UNITS 8'd1
`define PCT_DLY2_UNITS 8'd2
`define PCT_DLY3_UNITS 8'd4
`define PCT_DLY4_UNITS 8'd20
`define PCT_DLY5_UNITS 8'd40
`define PCT_DLY6_UNITS 8'd200
`endif

// ===== pct_pkg.sv
`include "pct_defs.svh"
package pct_pkg;
	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [2:0] {
		PCT_I_IDLE = 3'b000, PCT_I_RX = 3'b001, PCT_I_RACK = 3'b010,
		PCT_I_TX = 3'b011, PCT_I_TACK = 3'b100
	} pct_i2c_st_t;
	typedef enum logic [2:0] {
		PCT_P_IDLE = 3'b000, PCT_P_REQ = 3'b001, PCT_P_WAIT = 3'b010,
		PCT_P_GAP = 3'b011, PCT_P_DELAY = 3'b100
	} pct_poll_st_t;
	// ----------------------------------------
	// helpers shared by rx and tx paths
	// ----------------------------------------
	function automatic logic [7:0] pct_crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ `PCT_PEC_POLY) : (c << 1);
		return c;
	endfunction
	function automatic logic pct_is_err(input logic [15:0] v);
		return (v >= `PCT_ERR_LO) && (v <= `PCT_ERR_HI);
	endfunction
	// offset is kept in 16-bit form; alt keeps sign and whole degrees
	function automatic logic [15:0] pct_fmt(input logic [15:0] raw, input logic [15:0] off,
		input logic alt);
		logic [15:0] v;
		v = raw + off;
		if (pct_is_err(raw)) return raw;
		return alt ? {{8{v[15]}}, v[15], v[12:6]} : v;
	endfunction
endpackage

// ===== pct_i2c_if.sv
`timescale 1ns/100ps
// byte-level link between the bus slave and the register core
interface pct_i2c_if;
	logic start_p; // start seen
	logic stop_p; // stop or lockup timeout
	logic addr_p; // own address acked
	logic rd; // direction of current address
	logic rx_p; // data byte received
	logic [7:0] rx_byte;
	logic taken_p; // tx_byte loaded into shifter
	logic [7:0] tx_byte;
	logic [6:0] dev_addr;
	logic timeout_en;
	modport slave(input tx_byte, dev_addr, timeout_en,
		output start_p, stop_p, addr_p, rd, rx_p, rx_byte, taken_p);
	modport host(output tx_byte, dev_addr, timeout_en,
		input start_p, stop_p, addr_p, rd, rx_p, rx_byte, taken_p);
endinterface

// ===== pct_i2c_slave.sv
`timescale 1ns/100ps
module pct_i2c_slave import pct_pkg::*; #(
	parameter int TOUT_CYCLES = 600000
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	pct_i2c_if.slave bus
);
	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	logic [1:0] scl_sync_reg; // stage 0 read only by stage 1
	logic [1:0] sda_sync_reg;
	logic scl_d_reg, sda_d_reg;
	pct_i2c_st_t st_reg;
	logic [3:0] cnt_reg; // bit counter
	logic [7:0] sh_reg; // shift register
	logic first_reg, ack_reg;
	logic [19:0] tout_reg; // scl-low lockup counter
	wire scl_s = scl_sync_reg[1];
	wire sda_s = sda_sync_reg[1];
	wire rise = scl_s & ~scl_d_reg;
	wire fall = ~scl_s & scl_d_reg;
	wire start_w = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_w = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire tout_hit = tout_reg == 20'(TOUT_CYCLES - 1);
	wire go_tx = fall & (((st_reg == PCT_I_RACK) & bus.rd) | ((st_reg == PCT_I_TACK) & ack_reg));
	assign sda_out = 1'b0; // open drain: only low is driven
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{scl_sync_reg, sda_sync_reg, scl_d_reg, sda_d_reg} <= 6'h3F;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	// lockup: a master holding scl low too long frees the slave
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) tout_reg <= '0;
		else if (st_reg == PCT_I_IDLE || scl_s || !bus.timeout_en || tout_hit) tout_reg <= '0;
		else tout_reg <= tout_reg + 20'h1;
	end
	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= PCT_I_IDLE;
			{cnt_reg, sh_reg, first_reg, ack_reg, sda_oe} <= '0;
			{bus.start_p, bus.stop_p, bus.addr_p, bus.rd, bus.rx_p, bus.taken_p} <= '0;
			bus.rx_byte <= 8'h00;
		end else begin
			{bus.start_p, bus.stop_p, bus.addr_p, bus.rx_p, bus.taken_p} <= '0;
			if (stop_w || tout_hit) begin // abandon at once, release sda
				st_reg <= PCT_I_IDLE;
				sda_oe <= 1'b0;
				bus.stop_p <= 1'b1;
			end else if (start_w) begin // also repeated start
				st_reg <= PCT_I_RX;
				{cnt_reg, sda_oe} <= '0;
				first_reg <= 1'b1;
				bus.start_p <= 1'b1;
			end else if (go_tx) begin // next byte out, msb first
				sh_reg <= bus.tx_byte;
				sda_oe <= ~bus.tx_byte[7];
				cnt_reg <= 4'h0;
				bus.taken_p <= 1'b1;
				st_reg <= PCT_I_TX;
			end else begin
				unique case (st_reg)
					PCT_I_IDLE: ;
					PCT_I_RX: begin
						if (rise) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (fall && cnt_reg == 4'h8) begin
							first_reg <= 1'b0;
							if (!first_reg || sh_reg[7:1] == bus.dev_addr) begin
								sda_oe <= 1'b1; // ack
								st_reg <= PCT_I_RACK;
								bus.rx_byte <= sh_reg;
								bus.addr_p <= first_reg;
								bus.rx_p <= ~first_reg;
								if (first_reg) bus.rd <= sh_reg[0];
							end else begin
								st_reg <= PCT_I_IDLE; // not ours
							end
						end
					end
					PCT_I_RACK: if (fall) begin
						sda_oe <= 1'b0;
						cnt_reg <= 4'h0;
						st_reg <= PCT_I_RX;
					end
					PCT_I_TX: if (fall) begin
						if (cnt_reg == 4'h7) begin
							sda_oe <= 1'b0; // master acks
							st_reg <= PCT_I_TACK;
						end else begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							sda_oe <= ~sh_reg[6];
							cnt_reg <= cnt_reg + 4'h1;
						end
					end
					PCT_I_TACK: begin
						if (rise) ack_reg <= ~sda_s;
						else if (fall) st_reg <= PCT_I_IDLE; // nack ends the read
					end
				endcase
			end
		end
	end
	a_stop_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
		stop_w |=> !sda_oe && st_reg == PCT_I_IDLE) else $error("sda held after stop");
endmodule

// ===== pct_top.sv
`timescale 1ns/100ps
`include "pct_defs.svh"
module pct_top import pct_pkg::*; #(
	parameter int UNIT_CYCLES = `PCT_UNIT_US * (`PCT_CLK_HZ / 1000000),
	parameter int TOUT_CYCLES = `PCT_TOUT_US * (`PCT_CLK_HZ / 1000000)
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic slave_address_select_pin,
	output logic alert_n_out,
	output logic alert_n_oe,
	output logic poll_req,
	output logic [2:0] poll_target,
	output logic [7:0] poll_bit_time,
	input wire logic poll_done,
	input wire logic poll_ok,
	input wire logic [15:0] poll_data
);
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	pct_i2c_if bus();
	pct_i2c_slave #(.TOUT_CYCLES(TOUT_CYCLES)) u_slave (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.bus(bus)
	);
	assign scl_out = 1'b0; // never stretches the clock
	assign scl_oe = 1'b0;
	logic [1:0] adsel_sync_reg; // address strap, async pin
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) adsel_sync_reg <= 2'b00;
		else adsel_sync_reg <= {adsel_sync_reg[0], slave_address_select_pin};
	end
	assign bus.dev_addr = {`PCT_I2C_BASE, adsel_sync_reg[1]};
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [15:0] cfg0_reg, cfg1_reg, cfg3_reg;
	logic [15:0] off_reg; // offset always held in 16-bit form
	logic [15:0] lim_reg [4]; // per-socket limits
	logic [15:0] temp_reg [8]; // raw stored results
	logic [7:0] tvalid_reg; // entry holds a real read
	logic alert_reg;
	logic [2:0] alsrc_reg;
	// ----------------------------------------
	// transaction state
	// ----------------------------------------
	logic [7:0] cmd_reg, wlo_reg, hi_reg, crc_reg, tx_reg;
	logic [1:0] wcnt_reg, tstep_reg;
	logic pend_reg; // on-request poll waiting
	// ----------------------------------------
	// poll state
	// ----------------------------------------
	pct_poll_st_t pst_reg;
	logic [2:0] pidx_reg;
	logic [15:0] unit_cnt_reg; // 2.5 ms divider
	logic [7:0] units_reg, retry_reg;
	logic adv_reg; // move on after gap, else retry
	logic poll_req_reg;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [7:0] mask = cfg0_reg[15:`PCT_C0_MASK_LSB];
	wire alt = cfg0_reg[`PCT_C0_ALT];
	wire amask = cfg0_reg[`PCT_C0_AMASK];
	wire pec_en = cfg0_reg[`PCT_C0_PEC];
	wire [2:0] dly = cfg0_reg[2:0];
	wire periodic = (dly != 3'h0) && (dly != 3'h7);
	wire [7:0] dly_units = (dly == 3'h1) ? `PCT_DLY1_UNITS : (dly == 3'h2) ? `PCT_DLY2_UNITS :
		(dly == 3'h3) ? `PCT_DLY3_UNITS : (dly == 3'h4) ? `PCT_DLY4_UNITS :
		(dly == 3'h5) ? `PCT_DLY5_UNITS : `PCT_DLY6_UNITS;
	// offset seen in the current format
	wire [15:0] off_view = alt ? {{6{off_reg[15]}}, off_reg[15:6]} : off_reg;
	wire wr_commit = bus.rx_p && wcnt_reg == 2'h2 && !bus.rd;
	wire [15:0] wr_data = {bus.rx_byte, wlo_reg}; // low byte first
	wire send_byte = bus.stop_p && wcnt_reg == 2'h1 && !bus.rd;
	wire poll_cmd = send_byte && cmd_reg == `PCT_CMD_POLL;
	wire clr_w = send_byte && cmd_reg == `PCT_CMD_CLR_ALERT;
	assign bus.timeout_en = cfg0_reg[`PCT_C0_TOUT_EN];
	assign bus.tx_byte = tx_reg;
	// ----------------------------------------
	// maximum over enabled, valid entries
	// ----------------------------------------
	logic [15:0] max_val;
	logic [2:0] max_idx;
	logic max_any;
	always_comb begin
		max_val = 16'h0000;
		max_idx = 3'h0;
		max_any = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (mask[i] && tvalid_reg[i] && !pct_is_err(temp_reg[i]) &&
				(!max_any || $signed(temp_reg[i]) > $signed(max_val))) begin
				max_val = temp_reg[i];
				max_idx = 3'(i);
				max_any = 1'b1;
			end
		end
	end
	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'hFFFF; // unmapped commands
		if (cmd_reg <= `PCT_CMD_TEMP_LAST)
			rd_mux = pct_fmt(temp_reg[cmd_reg[2:0]], off_reg, alt);
		else if (cmd_reg >= `PCT_CMD_LIM0 && cmd_reg <= `PCT_CMD_LIM3)
			rd_mux = lim_reg[cmd_reg[1:0]];
		else begin
			unique case (cmd_reg)
				`PCT_CMD_MAX: rd_mux = max_any ? pct_fmt(max_val, off_reg, alt) : 16'hFFFF;
				`PCT_CMD_FW: rd_mux = `PCT_FW_VERSION;
				`PCT_CMD_MAX_SRC: rd_mux = max_any ? {13'h0000, max_idx} : `PCT_NO_SRC;
				`PCT_CMD_ALERT_SRC: rd_mux = alert_reg ? {13'h0000, alsrc_reg} : `PCT_NO_SRC;
				`PCT_CMD_CFG0: rd_mux = cfg0_reg;
				`PCT_CMD_CFG1: rd_mux = cfg1_reg;
				`PCT_CMD_CFG2: rd_mux = off_view;
				`PCT_CMD_CFG3: rd_mux = cfg3_reg;
				default: rd_mux = 16'hFFFF;
			endcase
		end
	end
	// ----------------------------------------
	// word protocol: command, low, high, pec
	// ----------------------------------------
	wire [7:0] crc_tx = pct_crc8(crc_reg, tx_reg);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{cmd_reg, wlo_reg, hi_reg, crc_reg, tx_reg} <= '0;
			{wcnt_reg, tstep_reg} <= '0;
		end else if (bus.addr_p) begin
			crc_reg <= pct_crc8(bus.rd ? crc_reg : 8'h00, bus.rx_byte);
			wcnt_reg <= bus.rd ? wcnt_reg : 2'h0;
			tx_reg <= rd_mux[7:0]; // low byte goes first
			hi_reg <= rd_mux[15:8];
			tstep_reg <= 2'h0;
		end else if (bus.rx_p) begin
			crc_reg <= pct_crc8(crc_reg, bus.rx_byte);
			if (wcnt_reg != 2'h3) wcnt_reg <= wcnt_reg + 2'h1;
			if (wcnt_reg == 2'h0) cmd_reg <= bus.rx_byte;
			if (wcnt_reg == 2'h1) wlo_reg <= bus.rx_byte;
		end else if (bus.taken_p) begin
			crc_reg <= crc_tx;
			if (tstep_reg != 2'h3) tstep_reg <= tstep_reg + 2'h1;
			unique case (tstep_reg)
				2'h0: tx_reg <= hi_reg;
				2'h1: tx_reg <= pec_en ? crc_tx : 8'hFF;
				default: tx_reg <= 8'hFF; // read past the word
			endcase
		end
	end
	// ----------------------------------------
	// config and limit writes
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg0_reg <= `PCT_CFG0_RST;
			cfg1_reg <= `PCT_CFG1_RST;
			off_reg <= `PCT_CFG2_RST;
			cfg3_reg <= `PCT_CFG3_RST;
			for (int i = 0; i < 4; i++) lim_reg[i] <= `PCT_LIMIT_RST;
		end else if (wr_commit) begin
			unique case (cmd_reg)
				`PCT_CMD_CFG0: cfg0_reg <= wr_data & `PCT_C0_WMASK; // bit 3 stays zero
				`PCT_CMD_CFG1: cfg1_reg <= wr_data;
				`PCT_CMD_CFG2: off_reg <= alt ? {wr_data[9:0], 6'h00} : wr_data;
				`PCT_CMD_CFG3: cfg3_reg <= wr_data;
				`PCT_CMD_LIM0, 8'h11, 8'h12, `PCT_CMD_LIM3: lim_reg[cmd_reg[1:0]] <= wr_data;
				default: ; // read-only or unmapped: ignored
			endcase
		end
	end
	// ----------------------------------------
	// result storage with averaging
	// ----------------------------------------
	wire store_w = pst_reg == PCT_P_WAIT && poll_done && poll_ok;
	wire [15:0] old_v = temp_reg[pidx_reg];
	wire [16:0] diff = {poll_data[15], poll_data} - {old_v[15], old_v};
	wire [16:0] step = $signed(diff) >>> cfg3_reg[7:0];
	wire avg_on = cfg3_reg[7:0] != 8'h00 && tvalid_reg[pidx_reg] &&
		!pct_is_err(poll_data) && !pct_is_err(old_v);
	wire [15:0] new_v = avg_on ? old_v + step[15:0] : poll_data;
	wire [15:0] new_out = pct_fmt(new_v, off_reg, alt);
	wire set_w = store_w && !pct_is_err(new_v) && !amask &&
		$signed(new_out) > $signed(lim_reg[pidx_reg[2:1]]);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) temp_reg[i] <= 16'h0000;
			tvalid_reg <= 8'h00;
		end else if (store_w) begin
			temp_reg[pidx_reg] <= new_v;
			tvalid_reg[pidx_reg] <= 1'b1;
		end
	end
	// ----------------------------------------
	// alert latch: a new violation beats a clear
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			alert_reg <= 1'b0;
			alsrc_reg <= 3'h0;
		end else if (set_w) begin
			alert_reg <= 1'b1;
			alsrc_reg <= pidx_reg;
		end else if (clr_w) begin
			alert_reg <= 1'b0;
		end
	end
	assign alert_n_out = 1'b0; // open drain, active low
	assign alert_n_oe = alert_reg & ~amask;
	// ----------------------------------------
	// poll scheduler
	// ----------------------------------------
	function automatic logic [3:0] next_en(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) if (i >= from && m[i]) r = {1'b1, 3'(i)};
		return r;
	endfunction
	wire tick = unit_cnt_reg == 16'(UNIT_CYCLES - 1);
	wire pass_go = pst_reg == PCT_P_IDLE && mask != 8'h00 && (pend_reg || periodic);
	wire [3:0] first_en = next_en(mask, 4'h0);
	wire [3:0] next_idx = next_en(mask, {1'b0, pidx_reg} + 4'h1);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) pend_reg <= 1'b0;
		else if (poll_cmd) pend_reg <= 1'b1; // request beats start of a pass
		else if (pass_go) pend_reg <= 1'b0;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) unit_cnt_reg <= 16'h0000;
		else if ((pst_reg != PCT_P_GAP && pst_reg != PCT_P_DELAY) || tick) unit_cnt_reg <= 16'h0000;
		else unit_cnt_reg <= unit_cnt_reg + 16'h0001;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pst_reg <= PCT_P_IDLE;
			{pidx_reg, units_reg, retry_reg, adv_reg, poll_req_reg} <= '0;
		end else begin
			poll_req_reg <= 1'b0;
			unique case (pst_reg)
				PCT_P_IDLE: if (pass_go) begin
					pidx_reg <= first_en[2:0];
					retry_reg <= 8'h00;
					pst_reg <= PCT_P_REQ;
				end
				PCT_P_REQ: begin
					poll_req_reg <= 1'b1;
					pst_reg <= PCT_P_WAIT;
				end
				PCT_P_WAIT: if (poll_done) begin
					adv_reg <= poll_ok || retry_reg >= cfg1_reg[7:0];
					if (!poll_ok) retry_reg <= retry_reg + 8'h01;
					units_reg <= 8'h00;
					pst_reg <= PCT_P_GAP;
				end
				PCT_P_GAP: if (tick) begin
					units_reg <= units_reg + 8'h01;
					if (!adv_reg) pst_reg <= PCT_P_REQ;
					else if (next_idx[3]) begin
						pidx_reg <= next_idx[2:0];
						retry_reg <= 8'h00;
						pst_reg <= PCT_P_REQ;
					end else if (periodic && units_reg + 8'h01 < dly_units)
						pst_reg <= PCT_P_DELAY;
					else pst_reg <= PCT_P_IDLE;
				end
				PCT_P_DELAY: if (tick) begin
					units_reg <= units_reg + 8'h01;
					if (units_reg + 8'h01 >= dly_units || !periodic) pst_reg <= PCT_P_IDLE;
				end
				default: pst_reg <= PCT_P_IDLE;
			endcase
		end
	end
	assign poll_req = poll_req_reg;
	assign poll_target = pidx_reg;
	assign poll_bit_time = cfg1_reg[15:8];
	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [16:0] since_done_reg; // cycles since last read ended
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) since_done_reg <= 17'h1FFFF;
		else if (poll_done) since_done_reg <= 17'h00000;
		else if (since_done_reg != 17'h1FFFF) since_done_reg <= since_done_reg + 17'h00001;
	end
	a_read_spacing: assert property (@(posedge ref_clk) disable iff (!reset_n)
		poll_req |-> since_done_reg >= 17'(UNIT_CYCLES)) else $error("reads too close");
	a_alert_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
		alert_n_oe |-> !cfg0_reg[`PCT_C0_AMASK]) else $error("alert driven while masked");
	a_alert_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
		set_w |=> alert_reg && alsrc_reg == $past(pidx_reg)) else $error("alert not latched");
	a_alert_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clr_w && !set_w |=> !alert_reg) else $error("alert clear lost");
	a_cfg_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
		wr_commit && cmd_reg == `PCT_CMD_CFG1 |=> cfg1_reg == $past(wr_data))
		else $error("config readback mismatch");
	a_err_passthru: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cmd_reg <= `PCT_CMD_TEMP_LAST && pct_is_err(temp_reg[cmd_reg[2:0]])
		|-> rd_mux == temp_reg[cmd_reg[2:0]]) else $error("error code altered");
	a_alt_sign: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cmd_reg <= `PCT_CMD_TEMP_LAST && alt && !pct_is_err(temp_reg[cmd_reg[2:0]])
		|-> rd_mux[15:8] == {8{rd_mux[7]}}) else $error("integer format not extended");
	a_on_request: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pst_reg == PCT_P_IDLE && !periodic && !pend_reg && !poll_cmd |=> pst_reg == PCT_P_IDLE)
		else $error("poll started unrequested");
	a_retry_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
		poll_req |-> retry_reg <= cfg1_reg[7:0]) else $error("too many retries");
	a_max_enabled: assert property (@(posedge ref_clk) disable iff (!reset_n)
		max_any |-> mask[max_idx] && tvalid_reg[max_idx]) else $error("max from disabled entry");
endmodule

// ===== pct_peci_model.sv
`timescale 1ns/100ps
// stand-in for the peci engine: answers each read a few clocks later
module pct_peci_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic poll_req,
	input wire logic [2:0] poll_target,
	output logic poll_done,
	output logic poll_ok,
	output logic [15:0] poll_data
);
	logic [3:0] cnt_reg; // clocks left in the read
	logic [15:0] val; // F600h plus one degree per index; index 5 answers an error code
	assign val = (poll_target == 3'h5) ? 16'h8100 : 16'hF600 + {7'h00, poll_target, 6'h00};
	// index 6 never reads cleanly, so every retry gets used up
	assign poll_ok = poll_done && (poll_target != 3'h6);
	// data only valid with done; junk otherwise so stale values cannot pass
	assign poll_data = poll_done ? val : ~val;
	// countdown from each request to a one-clock done
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 4'h0;
			poll_done <= 1'b0;
		end else begin
			poll_done <= (cnt_reg == 4'h1);
			cnt_reg <= poll_req ? 4'h6 : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : cnt_reg;
		end
	end
endmodule

// ===== pct_top_tb_top.sv
`timescale 1ns/100ps
module pct_top_tb_top;
	logic ref_clk = 1'b0; // starts low so reset spans four whole cycles
	logic reset_n, scl, sda_m, sda_oe, alert_n_oe, poll_req, poll_done, poll_ok;
	logic [8:0] r9; // bus bits seen during the lockup checks
	logic [2:0] poll_target;
	logic [7:0] bit_time;
	logic [15:0] poll_data;
	wire logic sda = sda_m & ~sda_oe; // open-drain wired and
	int n_fail = 0;
	int checked = 0;
	int n_req = 0; // read requests seen on the peci port
	int req_mark = 0; // n_req at the start of a window
	pct_top #(.UNIT_CYCLES(20), .TOUT_CYCLES(200)) u_pct_top (.ref_clk(ref_clk),
		.reset_n(reset_n), .scl_in(scl), .scl_out(), .scl_oe(), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .slave_address_select_pin(1'b0), .alert_n_out(),
		.alert_n_oe(alert_n_oe), .poll_req(poll_req), .poll_target(poll_target),
		.poll_bit_time(bit_time), .poll_done(poll_done), .poll_ok(poll_ok),
		.poll_data(poll_data));
	pct_peci_model u_pct_peci_model (.ref_clk(ref_clk), .reset_n(reset_n),
		.poll_req(poll_req), .poll_target(poll_target), .poll_done(poll_done),
		.poll_ok(poll_ok), .poll_data(poll_data));
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	// count peci read requests, one per pulse
	always @(posedge ref_clk) begin
		if (poll_req) n_req++;
	end
	// ----------------------------------------
	// bus tasks, all driven at falling edges
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk(input logic [7:0] id, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] item %h expected %h seen %h", id, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one 400 ns bit: long low phase so the slave's answer settles first
	task automatic xb(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			step(1);
			sda_m = d[i];
			step(4);
			scl = 1'b1;
			step(2);
			r[i] = sda;
			step(1);
			scl = 1'b0;
		end
	endtask
	task automatic start;
		step(1);
		sda_m = 1'b1;
		step(3);
		scl = 1'b1;
		step(3);
		sda_m = 1'b0;
		step(3);
		scl = 1'b0;
	endtask
	task automatic stop;
		step(1);
		sda_m = 1'b0;
		step(3);
		scl = 1'b1;
		step(3);
		sda_m = 1'b1;
		step(4);
	endtask
	// word write and send-byte: address 28h, pin strapped low
	task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input logic word);
		logic [8:0] a;
		start();
		xb(9'h0A1, a);
		xb({cmd, 1'b1}, a);
		if (word) begin
			xb({v[7:0], 1'b1}, a);
			xb({v[15:8], 1'b1}, a);
		end
		stop();
	endtask
	// word read, low byte first, nack after the high byte
	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		logic [8:0] a, lo, hi;
		start();
		xb(9'h0A1, a);
		xb({cmd, 1'b1}, a);
		start();
		xb(9'h0A3, a);
		xb(9'h1FE, lo);
		xb(9'h1FF, hi);
		stop();
		chk(cmd, {hi[8:1], lo[8:1]}, exp);
	endtask
	initial begin
		#3000000;
		n_fail++;
		final_report();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		reset_n = 1'b0;
		step(4);
		reset_n = 1'b1;
		step(3);
		chk(8'hB7, {8'h00, bit_time}, 16'h0002);
		rd(8'h0C, 16'h00A5);
		rd(8'h0D, 16'h0203);
		rd(8'h0E, 16'h0000);
		rd(8'h0F, 16'h0000);
		rd(8'h09, 16'h0100);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10 + 8'(i), 16'h1234 + 16'(i), 1'b1);
			rd(8'h10 + 8'(i), 16'h1234 + 16'(i));
		end
		wr(8'h0D, 16'h1405, 1'b1);
		rd(8'h0D, 16'h1405);
		chk(8'hB7, {8'h00, bit_time}, 16'h0014);
		wr(8'h0C, 16'h2380, 1'b1);
		wr(8'h14, 16'h0000, 1'b0);
		step(300);
		rd(8'h00, 16'hF600);
		rd(8'h01, 16'hF640);
		rd(8'h08, 16'hF640);
		rd(8'h0A, 16'h0001);
		wr(8'h0E, 16'h17C0, 1'b1);
		rd(8'h00, 16'h0DC0);
		wr(8'h0C, 16'h03C0, 1'b1);
		rd(8'h0E, 16'h005F);
		rd(8'h01, 16'h0038);
		rd(8'h05, 16'h8100);
		wr(8'h10, 16'h0037, 1'b1);
		wr(8'h14, 16'h0000, 1'b0);
		step(300);
		chk(8'hA0, {15'h0000, alert_n_oe}, 16'h0001);
		rd(8'h0B, 16'h0001);
		wr(8'h15, 16'h0000, 1'b0);
		chk(8'hA0, {15'h0000, alert_n_oe}, 16'h0000);
		rd(8'h0B, 16'h00FF);
		wr(8'h0C, 16'h03D0, 1'b1);
		wr(8'h14, 16'h0000, 1'b0);
		step(300);
		chk(8'hA0, {15'h0000, alert_n_oe}, 16'h0000);
		// delay code 0: no reads unless asked
		req_mark = n_req;
		step(300);
		chk(8'hD0, 16'(n_req - req_mark), 16'h0000);
		// index 6 always fails: one read plus every retry
		wr(8'h0C, 16'h4080, 1'b1);
		req_mark = n_req;
		wr(8'h14, 16'h0000, 1'b0);
		step(300);
		chk(8'hD1, 16'(n_req - req_mark), 16'h0006);
		// delay code 1: passes repeat with no request
		wr(8'h0C, 16'h0391, 1'b1);
		req_mark = n_req;
		step(300);
		chk(8'hD2, {15'h0000, (n_req - req_mark) >= 4}, 16'h0001);
		reset_n = 1'b0;
		step(4);
		reset_n = 1'b1;
		step(3);
		rd(8'h0C, 16'h00A5);
		rd(8'h10, 16'h7FFF);
		rd(8'h0D, 16'h0203);
		// lockup: hold scl low while the slave drives a zero data bit
		start();
		xb(9'h0A3, r9);
		step(250);
		chk(8'hC0, {15'h0000, sda_oe}, 16'h0000);
		stop();
		// timeout off: the slave keeps driving, then the byte is finished
		wr(8'h0C, 16'h0005, 1'b1);
		start();
		xb(9'h0A3, r9);
		step(250);
		chk(8'hC1, {15'h0000, sda_oe}, 16'h0001);
		xb(9'h1FF, r9);
		stop();
		final_report();
	end
endmodule
